// *** src/splc_dev_end.sv ***
// Link transmitter end: power state, clock-stop detection, far receiver
// calibration, PLL lock and the serial lanes toward the far receiver.
// Assumes a free running core clock and a pixel clock from the host.
//
// Behaviour
// [RL1] Sleep pin low powers down transmitter, link.
// [RL2] Auto mode: static pixel clock powers down.
// [RL3] Clock resumes: power up, calibrate, lock, stream.
// [RL4] Host keeps clock stops four periods long.
// [RL5] Link clock four or six times pixel.
// [RL6] Host keeps link clock at most 80 MHz.
// [RL7] Bits launched on both link clock edges.
// [RL8] No video before power, lock, calibration.
// [RL9] Lane code: 010 two, 100 three.
// [RL10] Host configures before starting the pixel clock.
// [RL11] Power-down clears locked and calibrated status.
`timescale 1ns/1ps
module splc_dev_end (
	// Core clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Link toward the host; the pixel clock comes in on it from the host.
	splc_link_if.dev link,
	// Serial side toward the far receiver.
	output logic serialLinkClock,
	output logic [splc_pkg::LANE_MAX-1:0] serialDataLane,
	// Status.
	output logic linkPowerOn,
	output logic calibrating,
	output logic pllLocked,
	output logic videoActive
);
	import splc_pkg::*;

	logic [PIX_W-1:0] pixHold_q;
	logic pixTgl_q;
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	logic [SYNC_W-1:0] sync3_q;
	logic [SYNC_W-1:0] stable_q;
	logic tglSeen_q;
	logic pixEvent;
	logic [7:0] idleCnt_q;
	logic clkRunning_q;
	splc_state_t state_q;
	splc_state_t state_d;
	logic [7:0] calCnt_q;
	logic [4:0] lockCnt_q;
	logic calibrated_q;
	logic locked_q;
	logic [LANE_CODE_W-1:0] laneCfg_q;
	logic [PIX_W-1:0] shift_q;
	logic [3:0] edgeLeft_q;
	logic sclk_q;
	logic [LANE_MAX-1:0] lane_q;
	logic powerOn_q;
	logic calibrating_q;
	logic videoActive_q;
	logic pinUp;
	logic autoMode;
	logic asleep;

	// Pixel clock domain: hold each word and flag it with a toggle. The
	// word stays put for a whole pixel period, long enough to cross.
	always_ff @(posedge link.pixelClock or negedge rst_b) begin
		if (!rst_b) begin
			pixHold_q <= '0;
			pixTgl_q <= 1'b0;
		end else begin
			pixHold_q <= link.pixelData;
			pixTgl_q <= ~pixTgl_q;
		end
	end

	// Three-stage synchroniser; a bit changes once stages two and three
	// agree, so a single metastable sample never counts.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_q <= SYNC_RST;
			sync2_q <= SYNC_RST;
			sync3_q <= SYNC_RST;
			stable_q <= SYNC_RST;
		end else begin
			sync1_q <= {pixTgl_q, link.sleepPinN, link.autoPowerDown,
				link.laneCode};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			stable_q <= (~(sync2_q ^ sync3_q) & sync3_q)
				| ((sync2_q ^ sync3_q) & stable_q);
		end
	end

	assign pinUp = stable_q[SI_SLEEP];
	assign autoMode = stable_q[SI_AUTO];
	assign pixEvent = stable_q[SI_TGL] != tglSeen_q;
	assign asleep = (state_d == ST_DOWN) || (state_d == ST_IDLE);

	// Clock-stop detector: no pixel edge for the detection time.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tglSeen_q <= 1'b0;
			idleCnt_q <= 8'h00;
			clkRunning_q <= 1'b0;
		end else begin
			tglSeen_q <= stable_q[SI_TGL];
			if (pixEvent) begin
				idleCnt_q <= 8'h00;
				clkRunning_q <= 1'b1;
			end else if (idleCnt_q == STOP_DET_CYC) begin
				clkRunning_q <= 1'b0; // RL2
			end else begin
				idleCnt_q <= idleCnt_q + 8'h01;
			end
		end
	end

	// Power state selection.
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_DOWN: begin
				if (pinUp && clkRunning_q) begin
					state_d = ST_CAL; // RL3
				end else if (pinUp && !autoMode) begin
					state_d = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (clkRunning_q) begin
					state_d = ST_CAL;
				end else if (autoMode) begin
					state_d = ST_DOWN; // RL2
				end
			end
			ST_CAL: begin
				if (calCnt_q == CAL_CYC) begin
					state_d = ST_LOCK; // RL3
				end
			end
			ST_LOCK: begin
				if (lockCnt_q == LOCK_PIXELS) begin
					state_d = ST_RUN; // RL3
				end
			end
			ST_RUN: begin
				state_d = ST_RUN;
			end
			default: begin
				state_d = ST_DOWN;
			end
		endcase
		if (state_q != ST_DOWN && state_q != ST_IDLE && !clkRunning_q) begin
			state_d = autoMode ? ST_DOWN : ST_IDLE; // RL2
		end
		if (!pinUp) begin
			state_d = ST_DOWN; // RL1
		end
	end

	// State register.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_DOWN;
		end else begin
			state_q <= state_d;
		end
	end

	// Calibration and lock progress; any power-down forgets both, so the
	// next wake-up walks the whole start sequence again.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			calCnt_q <= 8'h00;
			lockCnt_q <= 5'h00;
			calibrated_q <= 1'b0;
			locked_q <= 1'b0;
		end else if (asleep) begin
			calCnt_q <= 8'h00;
			lockCnt_q <= 5'h00;
			calibrated_q <= 1'b0; // RL11
			locked_q <= 1'b0; // RL11
		end else begin
			if (state_q == ST_CAL && calCnt_q != CAL_CYC) begin
				calCnt_q <= calCnt_q + 8'h01;
			end
			if (state_q == ST_CAL && calCnt_q == CAL_CYC) begin
				calibrated_q <= 1'b1; // RL3
			end
			if (state_q == ST_LOCK && pixEvent && lockCnt_q != LOCK_PIXELS) begin
				lockCnt_q <= lockCnt_q + 5'h01;
			end
			if (state_q == ST_LOCK && lockCnt_q == LOCK_PIXELS) begin
				locked_q <= 1'b1; // RL3
			end
		end
	end

	// Lane configuration is taken only while the link sleeps, since the
	// host changes it only with the pixel clock stopped.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			laneCfg_q <= LANE_CODE_RST; // RL9
		end else if (asleep) begin
			laneCfg_q <= stable_q[LANE_CODE_W-1:0]; // RL10
		end
	end

	// Serialiser. A pixel takes 8 or 12 link clock edges (4 or 6
	// periods) and every edge launches one bit per lane. A pixel that
	// arrives while the previous one is still going out is dropped.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_q <= '0;
			edgeLeft_q <= 4'h0;
			sclk_q <= 1'b0;
			lane_q <= '0;
		end else if (state_q == ST_CAL) begin
			sclk_q <= ~sclk_q;
			lane_q <= sclk_q ? CAL_PAT_A : CAL_PAT_B;
			edgeLeft_q <= 4'h0;
		end else if (edgeLeft_q != 4'h0) begin
			sclk_q <= ~sclk_q; // RL7
			if (lanesFromCode(laneCfg_q) == 2'h2) begin
				lane_q <= {1'b0, shift_q[PIX_W-1 -: 2]}; // RL9
				shift_q <= shift_q << 2;
			end else begin
				lane_q <= shift_q[PIX_W-1 -: 3];
				shift_q <= shift_q << 3;
			end
			edgeLeft_q <= edgeLeft_q - 4'h1;
		end else if (videoActive_q && pixEvent) begin
			shift_q <= pixHold_q; // RL8
			edgeLeft_q <= edgesFromCode(laneCfg_q); // RL5
		end else begin
			sclk_q <= 1'b0;
			lane_q <= '0;
		end
	end

	// Registered status.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			powerOn_q <= 1'b0;
			calibrating_q <= 1'b0;
			videoActive_q <= 1'b0;
		end else begin
			powerOn_q <= (state_d != ST_DOWN); // RL1
			calibrating_q <= (state_d == ST_CAL);
			videoActive_q <= (state_d == ST_RUN) && locked_q
				&& calibrated_q; // RL8
		end
	end

	assign link.videoReady = videoActive_q;
	assign serialLinkClock = sclk_q;
	assign serialDataLane = lane_q;
	assign linkPowerOn = powerOn_q;
	assign calibrating = calibrating_q;
	assign pllLocked = locked_q;
	assign videoActive = videoActive_q;

endmodule : splc_dev_end

// *** src/splc_host_end.sv ***
// Host end: drives the sleep pin, makes the pixel clock by a divider of
// its core clock, and launches pixel words and lane configuration.
// Assumes the transmitter end sits on the other side of the interface.
`timescale 1ns/1ps
module splc_host_end (
	// Core clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Link toward the transmitter.
	splc_link_if.host link,
	// User requests.
	input wire logic reqSleep,
	input wire logic reqClock,
	input wire logic [splc_pkg::PIX_W-1:0] pixelIn,
	input wire logic [splc_pkg::LANE_CODE_W-1:0] laneCodeIn,
	input wire logic autoIn,
	// User status.
	output logic pixelTaken,
	output logic clockRunning,
	output logic linkReady
);
	import splc_pkg::*;

	logic sleepPinN_q;
	logic running_q;
	logic pclk_q;
	logic [7:0] divCnt_q;
	logic [7:0] gapCnt_q;
	logic [PIX_W-1:0] pixelData_q;
	logic pixelTaken_q;
	logic [LANE_CODE_W-1:0] laneCode_q;
	logic auto_q;
	logic [2:0] readySync_q;
	logic readyStable_q;
	logic periodEnd;

	assign periodEnd = running_q && (divCnt_q == DIV_LAST);

	// Sleep pin follows the user request directly.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sleepPinN_q <= 1'b0;
		end else begin
			sleepPinN_q <= ~reqSleep; // RL1
		end
	end

	// Configuration only changes while the pixel clock is stopped.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			laneCode_q <= LANE_CODE_RST;
			auto_q <= 1'b0;
		end else if (!running_q) begin
			laneCode_q <= laneCodeIn; // RL10
			auto_q <= autoIn;
		end
	end

	// Pixel clock divider. Stops only at a whole period's end with the
	// clock low, then holds it low for the least stop gap.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			running_q <= 1'b0;
			pclk_q <= 1'b0;
			divCnt_q <= 8'h00;
			gapCnt_q <= 8'h00;
		end else if (!running_q) begin
			pclk_q <= 1'b0;
			divCnt_q <= 8'h00;
			if (gapCnt_q != 8'h00) begin
				gapCnt_q <= gapCnt_q - 8'h01; // RL4
			end else if (reqClock && sleepPinN_q) begin
				running_q <= 1'b1; // RL6
				pclk_q <= 1'b1;
			end
		end else if (periodEnd) begin
			divCnt_q <= 8'h00;
			if (!reqClock || !sleepPinN_q) begin
				running_q <= 1'b0;
				pclk_q <= 1'b0;
				gapCnt_q <= GAP_CYC; // RL4
			end else begin
				pclk_q <= 1'b1;
			end
		end else begin
			divCnt_q <= divCnt_q + 8'h01;
			if (divCnt_q == DIV_HALF - 8'h01) begin
				pclk_q <= 1'b0;
			end
		end
	end

	// New pixel on the falling edge; blank until the link reports ready.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pixelData_q <= '0;
			pixelTaken_q <= 1'b0;
		end else begin
			pixelTaken_q <= 1'b0;
			if (running_q && divCnt_q == DIV_HALF - 8'h01) begin
				pixelData_q <= readyStable_q ? pixelIn : '0; // RL8
				pixelTaken_q <= readyStable_q;
			end
		end
	end

	// Ready comes from the other domain; accept it once two stages agree.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			readySync_q <= 3'h0;
			readyStable_q <= 1'b0;
		end else begin
			readySync_q <= {readySync_q[1:0], link.videoReady};
			if (readySync_q[1] == readySync_q[2]) begin
				readyStable_q <= readySync_q[2];
			end
		end
	end

	assign link.pixelClock = pclk_q;
	assign link.sleepPinN = sleepPinN_q;
	assign link.pixelData = pixelData_q;
	assign link.laneCode = laneCode_q;
	assign link.autoPowerDown = auto_q;
	assign pixelTaken = pixelTaken_q;
	assign clockRunning = running_q;
	assign linkReady = readyStable_q;

endmodule : splc_host_end

// *** src/splc_link_if.sv ***
// Wires between the pixel clock host and the link transmitter.
// Assumes the bench joins one host end and one transmitter end.
`timescale 1ns/1ps
interface splc_link_if;
	import splc_pkg::*;

	// Pixel clock and sleep pin made by the host.
	logic pixelClock;
	logic sleepPinN;
	// Pixel word, launched on the falling pixel clock edge.
	logic [PIX_W-1:0] pixelData;
	// Configuration, held steady while the pixel clock runs.
	logic [LANE_CODE_W-1:0] laneCode;
	logic autoPowerDown;
	// Transmitter reports the link is ready for video.
	logic videoReady;

	modport dev (
		input pixelClock,
		input sleepPinN,
		input pixelData,
		input laneCode,
		input autoPowerDown,
		output videoReady
	);

	modport host (
		output pixelClock,
		output sleepPinN,
		output pixelData,
		output laneCode,
		output autoPowerDown,
		input videoReady
	);

endinterface : splc_link_if

// *** src/splc_pkg.sv ***
// Shared constants, types and decoders for the serial link power and
// clock control block: pixel clock host end and link transmitter end.
// Assumes a 100 MHz core clock on both ends.
package splc_pkg;

	// Core clock rate.
	localparam int CLK_MHZ = 100;

	// Pixel word and lane widths.
	localparam int PIX_W = 24;
	localparam int LANE_MAX = 3;
	localparam int LANE_CODE_W = 3;

	// Lane-count codes; every other code is reserved and acts as three.
	localparam logic [2:0] LANE_CODE_TWO = 3'h2;
	localparam logic [2:0] LANE_CODE_THREE = 3'h4;
	localparam logic [2:0] LANE_CODE_RST = LANE_CODE_THREE;

	// Link clock multipliers and serial limits.
	localparam int MULT_TWO = 6;
	localparam int MULT_THREE = 4;
	localparam int LINK_MAX_MHZ = 80;
	// Link clock edges per pixel: both edges launch a bit.
	localparam logic [3:0] EDGES_TWO = 4'(2 * MULT_TWO);
	localparam logic [3:0] EDGES_THREE = 4'(2 * MULT_THREE);

	// Pixel clock divider; never faster than the link limit allows.
	localparam int PCLK_DIV = 13;
	localparam int MIN_DIV = (CLK_MHZ * MULT_TWO + LINK_MAX_MHZ - 1)
		/ LINK_MAX_MHZ;
	localparam int DIV_EFF = (PCLK_DIV > MIN_DIV) ? PCLK_DIV : MIN_DIV;
	localparam logic [7:0] DIV_LAST = 8'(DIV_EFF - 1);
	localparam logic [7:0] DIV_HALF = 8'(DIV_EFF / 2);

	// Least pixel clock stop gap, in pixel periods and core cycles.
	localparam int STOP_GAP_PCLK = 4;
	localparam logic [7:0] GAP_CYC = 8'(STOP_GAP_PCLK * DIV_EFF);

	// Stop detection time, rounded up to core cycles.
	localparam int STOP_DET_NS = 300;
	localparam logic [7:0] STOP_DET_CYC =
		8'((STOP_DET_NS * CLK_MHZ + 999) / 1000);

	// Far receiver calibration time and PLL lock span.
	localparam int CAL_NS = 640;
	localparam logic [7:0] CAL_CYC = 8'((CAL_NS * CLK_MHZ + 999) / 1000);
	localparam logic [4:0] LOCK_PIXELS = 5'h10;

	// Calibration lane patterns.
	localparam logic [2:0] CAL_PAT_A = 3'h5;
	localparam logic [2:0] CAL_PAT_B = 3'h2;

	// Synchroniser bit positions on the transmitter end and reset value.
	localparam int SYNC_W = 6;
	localparam int SI_TGL = 5;
	localparam int SI_SLEEP = 4;
	localparam int SI_AUTO = 3;
	localparam logic [5:0] SYNC_RST = 6'h04;

	// Transmitter power states, Gray coded along the wake path.
	typedef enum logic [2:0] {
		ST_DOWN = 3'h0,
		ST_CAL = 3'h1,
		ST_LOCK = 3'h3,
		ST_RUN = 3'h2,
		ST_IDLE = 3'h6
	} splc_state_t;

	// Number of active lanes for a lane-count code.
	function automatic logic [1:0] lanesFromCode(input logic [2:0] code);
		return (code == LANE_CODE_TWO) ? 2'h2 : 2'h3;
	endfunction : lanesFromCode

	// Link clock edges needed to send one pixel.
	function automatic logic [3:0] edgesFromCode(input logic [2:0] code);
		return (code == LANE_CODE_TWO) ? EDGES_TWO : EDGES_THREE;
	endfunction : edgesFromCode

endpackage : splc_pkg

// *** testbench/serial_link_power_clock_control_tb.sv ***
// Bench joining one host end and one transmitter end over the link.
// Assumes both ends share clk; the host divides it into the pixel clock.
`timescale 1ns/1ps
module serial_link_power_clock_control_tb;
	import splc_pkg::*;
	typedef struct {
		logic [2:0] code;
		logic [3:0] edges;
		logic [23:0] pix;
	} splc_row_t;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic reqSleep = 1'b0;
	logic reqClock = 1'b0;
	logic autoIn = 1'b0;
	logic [PIX_W-1:0] pixelIn = '0;
	logic [2:0] laneCodeIn = LANE_CODE_RST;
	logic pixelTaken, clockRunning, linkReady, serialLinkClock;
	logic linkPowerOn, calibrating, pllLocked, videoActive;
	logic [LANE_MAX-1:0] serialDataLane;
	logic [3:0] n;
	logic [35:0] got, exp;
	int numErrors = 0;
	int samplesChecked = 0;
	int cycles = 0;
	int r, k;
	// Lane codes and edges per pixel; codes 0 and 7 are reserved.
	splc_row_t rows [4] = '{
		'{LANE_CODE_TWO, EDGES_TWO, 24'hC3_A55A},
		'{LANE_CODE_THREE, EDGES_THREE, 24'h5A_3C96},
		'{3'h0, EDGES_THREE, 24'h81_7EF0},
		'{3'h7, EDGES_THREE, 24'h0F_F00F}
	};

	splc_link_if link ();
	splc_host_end i_splc_host_end (.clk(clk), .rst_b(rst_b), .link(link),
		.reqSleep(reqSleep), .reqClock(reqClock), .pixelIn(pixelIn),
		.laneCodeIn(laneCodeIn), .autoIn(autoIn), .pixelTaken(pixelTaken),
		.clockRunning(clockRunning), .linkReady(linkReady));
	splc_dev_end i_splc_dev_end (.clk(clk), .rst_b(rst_b), .link(link),
		.serialLinkClock(serialLinkClock), .serialDataLane(serialDataLane),
		.linkPowerOn(linkPowerOn), .calibrating(calibrating),
		.pllLocked(pllLocked), .videoActive(videoActive));
	splc_link_properties i_splc_link_properties (.clk(clk), .rst_b(rst_b),
		.pixelClock(link.pixelClock), .sleepPinN(link.sleepPinN),
		.pixelData(link.pixelData), .laneCode(link.laneCode),
		.autoPowerDown(link.autoPowerDown), .videoReady(link.videoReady));

	// Core clock at 100 MHz.
	always #5 clk = ~clk;

	// Inputs always move 1 ns after the edge, away from sampling.
	task automatic step(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : step

	task automatic chk(input logic [35:0] seen, input logic [35:0] want);
		samplesChecked++;
		if (seen !== want) begin
			numErrors++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask : chk

	task automatic closeOut();
		$display("Checks %0d, errors %0d", samplesChecked, numErrors);
		if (numErrors == 0 && samplesChecked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : closeOut

	// Cut a hang short well past the expected run of some 3000 cycles.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 10000) begin
			numErrors++;
			closeOut();
		end
	end

	// Reset held 4 cycles; a second use lands in mid-run.
	task automatic doReset();
		rst_b = 1'b0;
		step(4);
		chk(36'({link.laneCode, videoActive, linkPowerOn, clockRunning}),
			36'({LANE_CODE_RST, 3'h0}));
		rst_b = 1'b1;
	endtask : doReset

	// Stop the clock, ask again inside the gap, which must be refused,
	// then change configuration only while the clock stands still.
	task automatic restart(input logic [2:0] code, input logic auto);
		logic was;
		int j;
		was = clockRunning;
		// Only drop the request when there is a clock to stop, so the
		// request is never written twice within one time step.
		if (was) begin
			reqClock = 1'b0;
		end
		for (j = 0; j < 30 && clockRunning !== 1'b0; j++) step(1);
		laneCodeIn = code;
		reqClock = 1'b1;
		step(45);
		if (was) begin
			chk(36'(clockRunning), 36'h0);
			chk(36'({pllLocked, videoActive}), 36'h0);
			chk(36'(linkPowerOn), 36'(!autoIn));
		end
		autoIn = auto;
		for (j = 0; j < 30 && clockRunning !== 1'b1; j++) step(1);
	endtask : restart

	// Wake must pass through calibration before video shows.
	task automatic waitReady();
		logic sawCal;
		int j;
		sawCal = 1'b0;
		for (j = 0; j < 800 && videoActive !== 1'b1; j++) begin
			sawCal = sawCal | calibrating;
			step(1);
		end
		chk(36'({sawCal, pllLocked, linkPowerOn, videoActive}),
			36'h0_000F);
	endtask : waitReady

	// Capture one whole burst; pixelIn is held so all bursts are alike.
	task automatic grabBurst();
		logic prev;
		int j;
		n = 4'h0;
		got = '0;
		prev = ~serialLinkClock;
		for (j = 0; j < 40 && serialLinkClock !== prev; j++) begin
			prev = serialLinkClock;
			step(1);
		end
		for (j = 0; j < 40 && serialLinkClock === prev; j++) step(1);
		for (j = 0; j < 13; j++) begin
			if (serialLinkClock !== prev) begin
				n = n + 4'h1;
				got = {got[32:0], serialDataLane};
			end
			prev = serialLinkClock;
			step(1);
		end
	endtask : grabBurst

	initial begin
		doReset();
		step(1);
		for (r = 0; r < 4; r++) begin
			restart(rows[r].code, 1'b0);
			pixelIn = rows[r].pix;
			waitReady();
			step(40);
			chk(36'({linkReady, link.laneCode}),
				36'({1'b1, rows[r].code}));
			// Once ready, each falling point takes the user word.
			for (k = 0; k < 14 && pixelTaken !== 1'b1; k++) step(1);
			chk(36'({pixelTaken, link.pixelData}), 36'({1'b1, rows[r].pix}));
			grabBurst();
			exp = '0;
			for (k = 0; k < 12; k++)
				exp = {exp[32:0], 1'b0, rows[r].pix[23-2*k -: 2]};
			if (rows[r].code != LANE_CODE_TWO) exp = 36'(rows[r].pix);
			chk(36'(n), 36'(rows[r].edges));
			chk(got, exp);
		end
		// Sleep pin while streaming, then wake again.
		reqSleep = 1'b1;
		step(20);
		chk(36'({link.sleepPinN, linkPowerOn, videoActive}), 36'h0);
		chk(36'({pllLocked, calibrating, serialLinkClock}), 36'h0);
		reqSleep = 1'b0;
		waitReady();
		// Auto mode: a clock stop must drop power, a restart rebuild.
		restart(LANE_CODE_THREE, 1'b1);
		waitReady();
		restart(LANE_CODE_TWO, 1'b1);
		waitReady();
		doReset();
		waitReady();
		closeOut();
	end
endmodule : serial_link_power_clock_control_tb

// *** testbench/splc_link_properties.sv ***
// Concurrent checks on the link between host end and transmitter end.
// Assumes both ends run from clk and it sees the interface signals.
`timescale 1ns/1ps
module splc_link_properties (
	// Core clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Link signals.
	input wire logic pixelClock,
	input wire logic sleepPinN,
	input wire logic [splc_pkg::PIX_W-1:0] pixelData,
	input wire logic [splc_pkg::LANE_CODE_W-1:0] laneCode,
	input wire logic autoPowerDown,
	input wire logic videoReady
);
	import splc_pkg::*;
	logic [7:0] lowRun_q;
	logic [7:0] quiet_q;
	logic [7:0] dark_q;
	logic [8:0] wake_q;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	// Low run of the pixel clock; saturates so a long stop never wraps.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) lowRun_q <= 8'hFF;
		else if (pixelClock) lowRun_q <= 8'h00;
		else if (lowRun_q != 8'hFF) lowRun_q <= lowRun_q + 8'h01;
	end

	// Samples since the pixel clock last moved.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) quiet_q <= 8'hFF;
		else if ($changed(pixelClock)) quiet_q <= 8'h00;
		else if (quiet_q != 8'hFF) quiet_q <= quiet_q + 8'h01;
	end

	// Samples with video off.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) dark_q <= 8'h00;
		else if (videoReady) dark_q <= 8'h00;
		else if (dark_q != 8'hFF) dark_q <= dark_q + 8'h01;
	end

	// Samples since the link was last woken by pin or clock.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) wake_q <= 9'h000;
		else if (!sleepPinN || quiet_q >= 8'h14) wake_q <= 9'h000;
		else if (wake_q != 9'h1FF) wake_q <= wake_q + 9'h001;
	end

	sequence s_highPhase;
		pixelClock [*6] ##1 !pixelClock;
	endsequence
	property p_clockShape;
		$rose(pixelClock) |-> s_highPhase;
	endproperty
	a_clockShape: assert property (p_clockShape)
		else $error("pixel clock high phase wrong");
	property p_stopGap;
		$rose(pixelClock) |-> lowRun_q == 8'h07 || lowRun_q >= 8'h34;
	endproperty
	a_stopGap: assert property (p_stopGap)
		else $error("pixel clock stop gap too short");
	property p_sleepOff;
		$fell(sleepPinN) |-> ##[1:12] !videoReady;
	endproperty
	a_sleepOff: assert property (p_sleepOff)
		else $error("video still on after sleep pin low");
	property p_stopOff;
		quiet_q >= 8'h32 |-> !videoReady;
	endproperty
	a_stopOff: assert property (p_stopOff)
		else $error("video on with pixel clock stopped");
	property p_wakeSeq;
		$rose(videoReady) |-> wake_q >= 9'h0F0 && quiet_q < 8'h08;
	endproperty
	a_wakeSeq: assert property (p_wakeSeq)
		else $error("video started before calibration and lock");
	property p_blankData;
		$fell(pixelClock) && dark_q >= 8'h18 |-> pixelData == '0;
	endproperty
	a_blankData: assert property (p_blankData)
		else $error("pixel data sent while link not ready");
	property p_cfgHold;
		lowRun_q < 8'h07 |-> $stable(laneCode) && $stable(autoPowerDown);
	endproperty
	a_cfgHold: assert property (p_cfgHold)
		else $error("configuration changed while clock runs");
	property p_laneReset;
		$rose(rst_b) |-> laneCode == LANE_CODE_RST;
	endproperty
	a_laneReset: assert property (p_laneReset)
		else $error("lane code not three lanes after reset");
endmodule : splc_link_properties
